// ===== inc/ccf_pkg.sv
/*
 * Constants for the capture/compare event flag block: register offsets,
 * flag bit positions, control field positions and reset values.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
// Operation
// - Rise flags: up-count match or rising capture
// - Fall flags: down-count match or falling capture
// - Flags stay set until explicitly reset
// - One-match flag on count one counting down
// - Period flag on period match counting up
// - Aux compare flag on aux compare match
// - Aux period flag on aux period match
// - Trap flag from enabled low pin or software
// - Exit mode 0: pin release clears trap flag
// - Exit mode 1: software clears trap flag
// - Trap state forces selected outputs passive
// - Trap state follows flag, clears per mode
// - Hall edge matching expected sets ok flag
// - Hall edge matching neither sets bad flag
// - Idle with bad flag, pattern zero, passive
// - Shadow transfer sets shadow done flag
// - Set register ones set flags, pulse requests
// - Set register always reads zero
// - Flag register ignores bus writes
// - Request pulse on every set condition
// - Clear register ones clear flags
package ccf_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_EVENT_FLAGS = 12'h10c;
    localparam logic [11:0] OFS_EVENT_FLAG_SET = 12'h110;
    localparam logic [11:0] OFS_EVENT_FLAG_CLEAR = 12'h114;
    localparam logic [11:0] OFS_TRAP_CONTROL_REG = 12'h120;
    localparam logic [11:0] OFS_PASSIVE_LEVEL_REG = 12'h124;
    localparam logic [11:0] OFS_HALL_PATTERN = 12'h128;
    localparam logic [11:0] OFS_MC_OUT_SHADOW = 12'h12c;
    localparam logic [11:0] OFS_MC_OUT_ACTIVE = 12'h130;

    // Flag bit positions in event_flags
    localparam int B_CHAN1_RISE = 2;
    localparam int B_CHAN1_FALL = 3;
    localparam int B_CHAN2_RISE = 4;
    localparam int B_CHAN2_FALL = 5;
    localparam int B_MAIN_ONE = 6;
    localparam int B_MAIN_PERIOD = 7;
    localparam int B_AUX_COMPARE = 8;
    localparam int B_AUX_PERIOD = 9;
    localparam int B_TRAP_FLAG = 10;
    localparam int B_TRAP_ACTIVE = 11;
    localparam int B_HALL_OK = 12;
    localparam int B_HALL_BAD = 13;
    localparam int B_IDLE = 14;
    localparam int B_SHADOW_DONE = 15;

    // Control register fields
    localparam int C_TRAP_PIN_ENABLE = 0;
    localparam int C_TRAP_EXIT_MODE = 1;
    localparam int C_TRAP_SYNC_MODE = 2;
    localparam int C_MC_MODE = 3;
    localparam int C_CHAN1_CAPTURE = 4;
    localparam int C_CHAN2_CAPTURE = 5;
    localparam int C_TRAP_SEL_LSB = 8;

    // Hall pattern register fields
    localparam int H_CURRENT_LSB = 0;
    localparam int H_EXPECTED_LSB = 3;

    // Reset values
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [13:0] RST_CONTROL = 14'h0000;
    localparam logic [5:0] RST_OUT6 = 6'h00;
    localparam logic [5:0] RST_HALL = 6'h00;
    localparam logic [31:0] RD_ZERO = 32'h00000000;

endpackage

// ===== rtl/ccf_event_flags.sv
/*
 * Event flag logic of a capture/compare unit with an APB register port:
 * sticky channel, timer, trap, hall, idle and shadow transfer flags,
 * their set and clear registers, trap state and passive output forcing.
 * Assumes timer, hall and shadow event inputs are one-cycle pulses
 * synchronous to pclk, and pin levels already synchronised to pclk.
 */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module ccf_event_flags #(
    parameter int NUM_OUTS = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] main_cmp_match,
    input wire logic main_count_down,
    input wire logic main_one_match,
    input wire logic main_period_match,
    input wire logic aux_compare_match,
    input wire logic aux_period_match,
    input wire logic chan1_pin,
    input wire logic chan2_pin,
    input wire logic trap_input_n,
    input wire logic trap_sync,
    input wire logic hall_edge,
    input wire logic [2:0] hall_inputs,
    input wire logic shadow_transfer,
    output logic [15:0] event_flags,
    output logic [15:0] flag_set_pulse,
    output logic [NUM_OUTS-1:0] out_level,
    output logic trap_active,
    output logic idle_state
);
    import ccf_pkg::*;

    // Register state. Everything here sits behind clk_en, so a low
    // enable freezes flags, configuration and the bus answer alike;
    // a bus master must not expect an answer while it is low.
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] set_pulse_q;
    logic [13:0] ctrl_q;
    logic [NUM_OUTS-1:0] passive_q;
    logic [5:0] hall_q;
    logic [NUM_OUTS-1:0] mc_shadow_q;
    logic [NUM_OUTS-1:0] mc_active_q;
    logic [NUM_OUTS-1:0] out_q;
    logic [1:0] pin_prev_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Bus decode. Only the low twelve address bits are compared, so the
    // block repeats through any wider window the interconnect gives it.
    // pslverr marks an unmapped address; the access still completes.
    wire logic setup_phase = psel & ~penable;
    wire logic access_done = psel & penable & pready_q;
    wire logic wr_en = access_done & pwrite;
    wire logic hit_flags = (paddr == OFS_EVENT_FLAGS);
    wire logic hit_set = (paddr == OFS_EVENT_FLAG_SET);
    wire logic hit_clear = (paddr == OFS_EVENT_FLAG_CLEAR);
    wire logic hit_ctrl = (paddr == OFS_TRAP_CONTROL_REG);
    wire logic hit_passive = (paddr == OFS_PASSIVE_LEVEL_REG);
    wire logic hit_hall = (paddr == OFS_HALL_PATTERN);
    wire logic hit_shadow = (paddr == OFS_MC_OUT_SHADOW);
    wire logic hit_active = (paddr == OFS_MC_OUT_ACTIVE);
    wire logic hit_any = hit_flags | hit_set | hit_clear | hit_ctrl
        | hit_passive | hit_hall | hit_shadow | hit_active;

    // Software set and clear strobes, one cycle at the access edge
    // They land at the same edge as hardware events, so a set and a
    // clear of one flag can meet; the flag update below settles that.
    wire logic [15:0] sw_set = (wr_en & hit_set) ? pwdata[15:0] : 16'h0000;
    wire logic [15:0] sw_clr_raw =
        (wr_en & hit_clear) ? pwdata[15:0] : 16'h0000;

    // Control fields. Mode bits and the trap output select share one
    // word, so a single write changes both together.
    wire logic trap_pin_enable = ctrl_q[C_TRAP_PIN_ENABLE];
    wire logic trap_exit_mode = ctrl_q[C_TRAP_EXIT_MODE];
    wire logic trap_sync_mode = ctrl_q[C_TRAP_SYNC_MODE];
    wire logic mc_mode = ctrl_q[C_MC_MODE];
    wire logic [1:0] capture_mode =
        {ctrl_q[C_CHAN2_CAPTURE], ctrl_q[C_CHAN1_CAPTURE]};
    wire logic [NUM_OUTS-1:0] trap_sel =
        ctrl_q[C_TRAP_SEL_LSB +: NUM_OUTS];
    wire logic [2:0] current_hall_pattern = hall_q[H_CURRENT_LSB +: 3];
    wire logic [2:0] expected_hall_pattern = hall_q[H_EXPECTED_LSB +: 3];

    // Channel pins gathered for the per-channel loop
    // Bit 0 is channel 1 and bit 1 channel 2, as on main_cmp_match
    wire logic [1:0] chan_pin = {chan2_pin, chan1_pin};
    logic [1:0] rise_set;
    logic [1:0] fall_set;

    // Capture edges or direction-qualified compare matches per channel
    // The pin history runs in every mode, so turning a channel over to
    // capture never reports an edge that happened before the switch;
    // a compare match only counts while its channel is not capturing.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            wire logic rise_edge = chan_pin[ch] & ~pin_prev_q[ch];
            wire logic fall_edge = ~chan_pin[ch] & pin_prev_q[ch];
            assign rise_set[ch] = capture_mode[ch] ? rise_edge
                : (main_cmp_match[ch] & ~main_count_down);
            assign fall_set[ch] = capture_mode[ch] ? fall_edge
                : (main_cmp_match[ch] & main_count_down);
        end
    endgenerate

    // Trap input: the pin only counts while the pin path is enabled
    // The pin is a level: held low, it sets the flag every cycle and a
    // request pulse goes out each time, which a handler must tolerate.
    wire logic trap_pin_hit = trap_pin_enable & ~trap_input_n;
    wire logic trap_pin_release = trap_pin_enable & trap_input_n;
    wire logic trap_hw_clear =
        ~trap_exit_mode & trap_pin_release;

    // Software hall compare acts like a valid hall edge
    // An input equal to the current pattern counts as a bounce back and
    // sets neither hall flag.
    wire logic hall_cmp = hall_edge | sw_set[B_TRAP_ACTIVE];
    wire logic hall_good =
        hall_cmp & (hall_inputs == expected_hall_pattern);
    wire logic hall_wrong = hall_cmp
        & (hall_inputs != expected_hall_pattern)
        & (hall_inputs != current_hall_pattern);

    // Shadow transfer counts only in multi-channel mode
    // Outside that mode the transfer strobe is ignored entirely.
    wire logic shadow_evt = mc_mode & shadow_transfer;

    // Hardware set conditions by flag position
    // Bits without a source here stay zero; the channel-0 positions
    // belong to logic outside this block.
    logic [15:0] hw_set;
    always_comb
    begin
        hw_set = 16'h0000;
        hw_set[B_CHAN1_RISE] = rise_set[0];
        hw_set[B_CHAN1_FALL] = fall_set[0];
        hw_set[B_CHAN2_RISE] = rise_set[1];
        hw_set[B_CHAN2_FALL] = fall_set[1];
        hw_set[B_MAIN_ONE] = main_one_match & main_count_down;
        hw_set[B_MAIN_PERIOD] =
            main_period_match & ~main_count_down;
        hw_set[B_AUX_COMPARE] = aux_compare_match;
        hw_set[B_AUX_PERIOD] = aux_period_match;
        hw_set[B_TRAP_FLAG] = trap_pin_hit;
        hw_set[B_HALL_OK] = hall_good;
        hw_set[B_HALL_BAD] = hall_wrong;
        hw_set[B_IDLE] = hall_wrong;
        hw_set[B_SHADOW_DONE] = shadow_evt;
    end

    // All set conditions; the hall compare strobe is not itself a flag,
    // while a software trap set also raises the trap state
    logic [15:0] any_set;
    always_comb
    begin
        any_set = hw_set | sw_set;
        any_set[B_TRAP_ACTIVE] = sw_set[B_TRAP_FLAG];
        // Channel-0 positions are not implemented: a write never sets
        // them, so they keep reading zero
        any_set[1:0] = 2'b00;
    end

    // Software clear of the trap flag is ignored while the pin still traps;
    // the trap state bit has no clear of its own, leaving the state is
    // the job of the synchronisation logic below
    logic [15:0] sw_clr;
    always_comb
    begin
        sw_clr = sw_clr_raw;
        sw_clr[B_TRAP_FLAG] = sw_clr_raw[B_TRAP_FLAG] & ~trap_pin_hit;
        sw_clr[B_TRAP_ACTIVE] = 1'b0;
    end

    // Trap state leaves only when the flag is down and the chosen
    // synchronisation has come; it is never cleared by a write
    // With sync mode 0 the state ends in the same cycle as the flag;
    // with sync mode 1 it waits for the next trap_sync pulse, so the
    // outputs stay passive until the timer reaches a safe point.
    wire logic trap_flag_next = any_set[B_TRAP_FLAG]
        | (flags_q[B_TRAP_FLAG] & ~sw_clr[B_TRAP_FLAG]
        & ~trap_hw_clear);
    wire logic trap_leave = ~trap_flag_next
        & (~trap_sync_mode | trap_sync);

    // Next flag value: set wins over clear so no event is lost
    // The trap state bit takes a path of its own: it follows the flag up
    // at once but comes down only when trap_leave allows.
    always_comb
    begin
        flags_d = any_set | (flags_q & ~sw_clr);
        flags_d[B_TRAP_FLAG] = trap_flag_next;
        flags_d[B_TRAP_ACTIVE] = trap_flag_next | any_set[B_TRAP_ACTIVE]
            | (flags_q[B_TRAP_ACTIVE] & ~trap_leave);
    end

    // Output pattern: passive levels during trap state or idle
    // Idle forces every output, trap only the selected ones; both use
    // the next flag value so the outputs switch with the flags.
    wire logic idle_next = flags_d[B_IDLE];
    wire logic [NUM_OUTS-1:0] force_sel =
        idle_next ? {NUM_OUTS{1'b1}}
        : (flags_d[B_TRAP_ACTIVE] ? trap_sel : {NUM_OUTS{1'b0}});
    wire logic [NUM_OUTS-1:0] mc_active_d = idle_next ? {NUM_OUTS{1'b0}}
        : (shadow_evt ? mc_shadow_q : mc_active_q);
    wire logic [NUM_OUTS-1:0] out_d =
        (passive_q & force_sel) | (mc_active_d & ~force_sel);

    // Read data selection; write-only and reserved bits read zero, except control bits 7:6, which read back as written
    // Unmapped addresses also read zero; pslverr marks them, and the
    // active pattern reads back what the outputs are built from.
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = RD_ZERO;
        if (hit_flags)
        begin
            rd_mux[15:0] = flags_q;
        end
        else if (hit_ctrl)
        begin
            rd_mux[13:0] = ctrl_q;
        end
        else if (hit_passive)
        begin
            rd_mux[NUM_OUTS-1:0] = passive_q;
        end
        else if (hit_hall)
        begin
            rd_mux[5:0] = hall_q;
        end
        else if (hit_shadow)
        begin
            rd_mux[NUM_OUTS-1:0] = mc_shadow_q;
        end
        else if (hit_active)
        begin
            rd_mux[NUM_OUTS-1:0] = mc_active_q;
        end
        // Set and clear registers fall through to zero
    end

    // APB slave: answer one cycle after setup, read data captured at the
    // setup edge. A flag that sets in that same cycle shows on the next
    // read; this trades one cycle of staleness for a registered prdata
    // with no combinational path from the access phase to the bus.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= RD_ZERO;
        end
        else if (clk_en)
        begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase & ~hit_any;
            prdata_q <= (setup_phase & ~pwrite) ? rd_mux : RD_ZERO;
        end
    end

    // Software-written configuration; writes to the flag register are
    // dropped because it has no write path at all
    // The active pattern is read-only for the same reason.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= RST_CONTROL;
            passive_q <= RST_OUT6[NUM_OUTS-1:0];
            hall_q <= RST_HALL;
            mc_shadow_q <= RST_OUT6[NUM_OUTS-1:0];
        end
        else if (clk_en & wr_en)
        begin
            if (hit_ctrl)
            begin
                ctrl_q <= pwdata[13:0];
            end
            if (hit_passive)
            begin
                passive_q <= pwdata[NUM_OUTS-1:0];
            end
            if (hit_hall)
            begin
                hall_q <= pwdata[5:0];
            end
            if (hit_shadow)
            begin
                mc_shadow_q <= pwdata[NUM_OUTS-1:0];
            end
        end
    end

    // Flags, request pulses and the output stage
    // The pin history is clocked with the flags, so an edge that sets a
    // capture flag is seen exactly once.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_q <= RST_FLAGS;
            set_pulse_q <= RST_FLAGS;
            mc_active_q <= RST_OUT6[NUM_OUTS-1:0];
            out_q <= RST_OUT6[NUM_OUTS-1:0];
            pin_prev_q <= 2'b00;
        end
        else if (clk_en)
        begin
            flags_q <= flags_d;
            set_pulse_q <= any_set;
            mc_active_q <= mc_active_d;
            out_q <= out_d;
            pin_prev_q <= chan_pin;
        end
    end

    // Outputs straight from flip-flops
    // trap_active and idle_state are plain copies of their flag bits
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign event_flags = flags_q;
    assign flag_set_pulse = set_pulse_q;
    assign out_level = out_q;
    assign trap_active = flags_q[B_TRAP_ACTIVE];
    assign idle_state = flags_q[B_IDLE];

endmodule // ccf_event_flags

`default_nettype wire

// ===== tb/ccf_event_flags_sva.sv
/* Checker for the event flag block: APB answer timing, flag setting,
   stickiness, trap state and the set register read value.
   Assumes it is bound to ccf_event_flags with one clock domain. */
`timescale 1ns/1ps
`default_nettype none

module ccf_event_flags_sva
    import ccf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic main_one_match,
    input wire logic main_count_down,
    input wire logic main_period_match,
    input wire logic aux_compare_match,
    input wire logic aux_period_match,
    input wire logic [15:0] event_flags,
    input wire logic [15:0] flag_set_pulse,
    input wire logic trap_active
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A completed write to the clear register; the only way a flag outside the trap bits drops
    logic clr_wr;
    logic [11:0] sticky;
    assign clr_wr = psel && penable && pready && pwrite
        && paddr == OFS_EVENT_FLAG_CLEAR;
    assign sticky = {event_flags[15:12], event_flags[9:2]};

    a_apb_answer: assert property (clk_en && psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    a_aux_period: assert property (clk_en && aux_period_match |=>
        event_flags[B_AUX_PERIOD] && flag_set_pulse[B_AUX_PERIOD])
        else $error("aux period flag or pulse missing");
    a_aux_compare: assert property (clk_en && aux_compare_match |=>
        event_flags[B_AUX_COMPARE])
        else $error("aux compare flag missing");
    a_one_match: assert property (clk_en && main_one_match
        && main_count_down |=> event_flags[B_MAIN_ONE]
        && flag_set_pulse[B_MAIN_ONE])
        else $error("one match flag missing");
    a_period_match: assert property (clk_en && main_period_match
        && !main_count_down |=> event_flags[B_MAIN_PERIOD])
        else $error("period match flag missing");
    a_flags_sticky: assert property (|($past(sticky) & ~sticky) |->
        $past(clr_wr) || $past(clr_wr, 2))
        else $error("flag dropped without a clear write");
    a_trap_state: assert property (event_flags[B_TRAP_FLAG] |->
        trap_active)
        else $error("trap flag set without trap state");
    a_set_zero: assert property (psel && pready && !pwrite
        && paddr == OFS_EVENT_FLAG_SET |-> prdata == RD_ZERO)
        else $error("set register read not zero");
endmodule // ccf_event_flags_sva

bind ccf_event_flags ccf_event_flags_sva u_sva (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .main_one_match(main_one_match),
    .main_count_down(main_count_down),
    .main_period_match(main_period_match),
    .aux_compare_match(aux_compare_match),
    .aux_period_match(aux_period_match), .event_flags(event_flags),
    .flag_set_pulse(flag_set_pulse), .trap_active(trap_active)
);

`default_nettype wire

// ===== tb/ccf_event_flags_tb.sv
/* Self-checking bench for the event flag block: APB access, hardware
   events, capture, trap and hall flags against a bench model.
   Assumes the block answers every APB access within twenty cycles. */
`timescale 1ns/1ps
`default_nettype none

module ccf_event_flags_tb;
    import ccf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [1:0] cmp;
    logic cnt_dn, one_m, per_m, aux_c, aux_p, ch1, ch2, trap_n, hedge, shd;
    logic [2:0] hall;
    logic [15:0] flags, fpulse;
    logic [5:0] outs;
    logic trap_act, idle, tsync, cken;
    int failures, compares, exp_flags;
    int evs[9] = '{2, 3, 4, 5, 6, 7, 8, 9, 15};

    // Clock enable and trap sync come from the bench
    ccf_event_flags uut (
        .pclk(pclk), .presetn(presetn), .clk_en(cken), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_cmp_match(cmp), .main_count_down(cnt_dn),
        .main_one_match(one_m), .main_period_match(per_m),
        .aux_compare_match(aux_c), .aux_period_match(aux_p),
        .chan1_pin(ch1), .chan2_pin(ch2), .trap_input_n(trap_n),
        .trap_sync(tsync), .hall_edge(hedge), .hall_inputs(hall),
        .shadow_transfer(shd), .event_flags(flags), .flag_set_pulse(fpulse),
        .out_level(outs), .trap_active(trap_act), .idle_state(idle)
    );

    // Free-running 40 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic finish_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, then an idle cycle so psel is never set twice
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] v);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (n == 20)
            failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Read the flag register and the flag port against the model
    task automatic rdflags;
        repeat (2) @(posedge pclk);
        apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
        chk(rd, exp_flags);
        chk({16'h0, flags}, exp_flags);
    endtask

    // One-cycle pulse on a hardware event source, flag seen next cycle
    task automatic fire(input int b);
        case (b)
            2, 3: cmp <= 2'b01;
            4, 5: cmp <= 2'b10;
            6: one_m <= 1'b1;
            7: per_m <= 1'b1;
            8: aux_c <= 1'b1;
            9: aux_p <= 1'b1;
            default: shd <= 1'b1;
        endcase
        cnt_dn <= (b == 3 || b == 5 || b == 6); // One-match counts down
        @(posedge pclk);
        {cmp, one_m, per_m, aux_c, aux_p, shd} <= '0;
        exp_flags |= 1 << b;
        @(negedge pclk);
        chk({31'h0, fpulse[b]}, 32'h1);
        chk({16'h0, flags}, exp_flags);
        @(posedge pclk);
    endtask

    task automatic hpulse(input logic [2:0] h);
        hall <= h;
        hedge <= 1'b1;
        @(posedge pclk);
        hedge <= 1'b0;
    endtask

    // Watchdog: the sequence needs well under 1000 cycles
    initial
    begin
        repeat (4000) @(posedge pclk);
        failures++;
        finish_test;
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, presetn} <= '0;
        {cmp, cnt_dn, one_m, per_m, aux_c, aux_p, ch1, ch2, hedge} <= '0;
        {shd, hall, trap_n} <= 5'h01;
        {tsync, cken} <= 2'b01;
        void'($urandom(32'h4fa4));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdflags;
        apb(1'b0, OFS_EVENT_FLAG_SET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'hffc, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, OFS_TRAP_CONTROL_REG, 32'h8);
        foreach (evs[i])
            fire(evs[i]);
        apb(1'b1, OFS_EVENT_FLAGS, 32'h0);
        rdflags;
        apb(1'b1, OFS_EVENT_FLAG_CLEAR, 32'hf0);
        exp_flags &= ~32'hf0;
        rdflags;
        $display("test events done");
        d = $urandom & 32'hffff93fc;
        apb(1'b1, OFS_EVENT_FLAG_SET, d);
        exp_flags |= d & 32'h93fc;
        rdflags;
        apb(1'b1, OFS_EVENT_FLAG_CLEAR, 32'hffff);
        exp_flags = 0;
        rdflags;
        // A match while the clock enable is low must be lost
        cken <= 1'b0;
        aux_c <= 1'b1;
        @(posedge pclk);
        {aux_c, cken} <= 2'b01;
        rdflags;
        apb(1'b1, OFS_TRAP_CONTROL_REG, 32'h30);
        {ch1, ch2} <= 2'b11;
        exp_flags = 32'h14;
        rdflags;
        {ch1, ch2} <= 2'b00;
        exp_flags |= 32'h28;
        rdflags;
        $display("test set and capture done");
        apb(1'b1, OFS_PASSIVE_LEVEL_REG, 32'h2a);
        apb(1'b1, OFS_TRAP_CONTROL_REG, 32'h3f01);
        trap_n <= 1'b0;
        exp_flags |= 32'hc00;
        rdflags;
        chk({26'h0, outs}, 32'h2a);
        apb(1'b1, OFS_EVENT_FLAG_CLEAR, 32'h400);
        rdflags;
        trap_n <= 1'b1;
        exp_flags &= ~32'hc00;
        rdflags;
        apb(1'b1, OFS_TRAP_CONTROL_REG, 32'h3f03);
        trap_n <= 1'b0;
        repeat (3) @(posedge pclk);
        trap_n <= 1'b1;
        exp_flags |= 32'hc00;
        rdflags;
        apb(1'b1, OFS_EVENT_FLAG_CLEAR, 32'h400);
        exp_flags &= ~32'hc00;
        rdflags;
        // Sync mode 1: trap state outlives the flag until a sync pulse
        apb(1'b1, OFS_TRAP_CONTROL_REG, 32'h3f05);
        trap_n <= 1'b0;
        exp_flags |= 32'hc00;
        rdflags;
        trap_n <= 1'b1;
        exp_flags &= ~32'h400;
        rdflags;
        chk({31'h0, trap_act}, 32'h1);
        chk({26'h0, outs}, 32'h2a);
        tsync <= 1'b1;
        @(posedge pclk);
        tsync <= 1'b0;
        exp_flags &= ~32'h800;
        rdflags;
        chk({26'h0, outs}, 32'h0);
        $display("test trap done");
        apb(1'b1, OFS_TRAP_CONTROL_REG, 32'h0);
        apb(1'b1, OFS_HALL_PATTERN, 32'h19);
        hpulse(3'b001);
        rdflags;
        hpulse(3'b110);
        exp_flags |= 32'h6000;
        rdflags;
        chk({31'h0, idle}, 32'h1);
        chk({26'h0, outs}, 32'h2a);
        hpulse(3'b011);
        exp_flags |= 32'h1000;
        rdflags;
        $display("test hall done");
        finish_test;
    end
endmodule // ccf_event_flags_tb

`default_nettype wire
